/* verilog/serial_port_params.svh */
// timing, field and reset constants for the serial module host port
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define CLK_PERIOD_NS 25
`define DIV_WIDTH 4
`define DIV_RESET 4'h0
`define DIV_HALF_BIT 0
`define DIV_SIXTEENTH_BIT 3
`define CNT_WIDTH 16
`define CNT_RESET 16'h0000
`define CTRL_RESET 8'h00
`define TIMER_CTRL_ADDR 2'h3
`define TIMER_CHAN_CNT 3
`define SC_DATA_ADDR 1'b0
`define SC_CTRL_ADDR 1'b1
`define SC_STATUS_TX_READY_FLAG_BIT 0
`endif

/* verilog/serial_port_pkg.sv */
// types shared by the serial module host port
package serial_port_pkg;
  typedef enum logic [2:0]
  {
    SC_IDLE = 3'b001,
    SC_WAIT_CMD = 3'b010,
    SC_RUN = 3'b100
  } sc_state_type;
  typedef enum logic [1:0]
  {
    IRQ_SRC_TIMER_A = 2'h0,
    IRQ_SRC_TIMER_B = 2'h1,
    IRQ_SRC_TX_READY = 2'h2,
    IRQ_SRC_OFF = 2'h3
  } irq_src_type;
endpackage

/* verilog/timer_counter.sv */
// one down counter of the interval timer, square-wave style output
`timescale 1ns/1ps
`include "serial_port_params.svh"
module timer_counter
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic load_high,
  output logic [`CNT_WIDTH-1:0] count,
  output logic out
);
  logic [`CNT_WIDTH-1:0] reload_ff; // programmed divisor
  logic [`CNT_WIDTH-1:0] nxt_reload;
  logic [`CNT_WIDTH-1:0] count_ff; // running count
  logic [`CNT_WIDTH-1:0] nxt_count;
  logic out_ff; // toggles at each terminal count
  logic nxt_out;

  // next-state: byte loads and counting on tick
  always_comb
  begin
    nxt_reload = reload_ff;
    nxt_count = count_ff;
    nxt_out = out_ff;
    if (load)
    begin
      // byte load; low first then high
      if (load_high)
      begin
        nxt_reload = {load_data, reload_ff[7:0]};
        nxt_count = {load_data, reload_ff[7:0]};
      end
      else
      begin
        nxt_reload = {reload_ff[15:8], load_data};
      end
    end
    else if (tick)
    begin
      // reload at one and toggle the output
      if (count_ff <= 16'h0001)
      begin
        nxt_count = reload_ff;
        nxt_out = ~out_ff;
      end
      else
      begin
        nxt_count = count_ff - 16'h0001;
      end
    end
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reload_ff <= `CNT_RESET;
      count_ff <= `CNT_RESET;
      out_ff <= 1'b0;
    end
    else
    begin
      reload_ff <= nxt_reload;
      count_ff <= nxt_count;
      out_ff <= nxt_out;
    end
  end

  assign count = count_ff;
  assign out = out_ff;
endmodule

/* verilog/serial_module_host_port.sv */
// host-side attachment logic of the plug-in serial module
// Contract
// - reset idles serial controller until new control words
// - address bit zero picks internal register
// - both address bits pick timer counter or control
// - read returns controller data/status or counter value
// - write stores controller words or timer loads
// - controller ignores strobes, floats bus when deselected
// - timer select gates access only, counters run
// - eight-bit bidirectional data bus carries all traffic
// - each interrupt jumpered to timer a, b, or ready
// - four-bit counter divides base clock by two, sixteen
// - third counter output toggled only at its own terminal count
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_module_host_port
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_bit0,
  input wire logic addr_bit1,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic serial_ctrl_select_n,
  input wire logic timer_select_n,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe,
  input wire logic [1:0] irq_a_jumper,
  input wire logic [1:0] irq_b_jumper,
  output logic irq_out_a,
  output logic irq_out_b,
  output logic timer_out_c,
  output logic tx_ready_flag,
  output logic module_present_n
);
  // decode of the timer channel from the two address bits
  function automatic logic chan_hit(input logic [1:0] addr, input int idx);
    chan_hit = (addr == idx[1:0]);
  endfunction
  // pick an interrupt source by jumper
  function automatic logic irq_pick(input logic [1:0] sel, input logic ta,
                                    input logic tb, input logic rdy);
    case (sel)
      IRQ_SRC_TIMER_A: irq_pick = ta;
      IRQ_SRC_TIMER_B: irq_pick = tb;
      IRQ_SRC_TX_READY: irq_pick = rdy;
      default: irq_pick = 1'b0;
    endcase
  endfunction
  logic [1:0] addr; // combined address bits
  logic wr_strobe_ff; // delayed write strobe for edge detect
  logic nxt_wr_strobe;
  logic wr_edge; // one-cycle write pulse at strobe end
  logic sc_wr; // controller write, gated by its select
  logic tm_wr; // timer write, gated by its select
  assign addr = {addr_bit1, addr_bit0};
  assign wr_edge = wr_strobe_ff & host_write_strobe_n;
  assign sc_wr = wr_edge & ~serial_ctrl_select_n;
  assign tm_wr = wr_edge & ~timer_select_n;
  // strobe history next value
  always_comb
  begin
    nxt_wr_strobe = ~host_write_strobe_n;
  end
  // strobe history register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_strobe_ff <= 1'b0;
    end
    else
    begin
      wr_strobe_ff <= nxt_wr_strobe;
    end
  end
  // clock division chain
  logic [`DIV_WIDTH-1:0] div_ff; // free-running four-bit counter
  logic [`DIV_WIDTH-1:0] nxt_div;
  logic [`DIV_WIDTH-1:0] div_prev_ff; // previous value for edge ticks
  logic half_tick; // rising edge of divide-by-two
  logic sixteenth_tick; // rising edge of divide-by-sixteen
  // synchronous counter next value
  always_comb
  begin
    nxt_div = div_ff + 4'h1;
  end
  // counter registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      div_ff <= `DIV_RESET;
      div_prev_ff <= `DIV_RESET;
    end
    else
    begin
      div_ff <= nxt_div;
      div_prev_ff <= div_ff;
    end
  end
  // ticks from counter bit rises: divide by two and sixteen
  assign half_tick = div_ff[`DIV_HALF_BIT] & ~div_prev_ff[`DIV_HALF_BIT];
  assign sixteenth_tick = div_ff[`DIV_SIXTEENTH_BIT] &
                          ~div_prev_ff[`DIV_SIXTEENTH_BIT];

  // timer control word and byte pointers
  logic [7:0] tm_ctrl_ff; // last control word
  logic [7:0] nxt_tm_ctrl;
  logic [`TIMER_CHAN_CNT-1:0] high_ptr_ff; // next byte is high byte
  logic [`TIMER_CHAN_CNT-1:0] nxt_high_ptr;
  logic [`TIMER_CHAN_CNT-1:0] tm_load; // per-channel load pulse
  logic [`TIMER_CHAN_CNT-1:0] tm_out; // per-channel output
  logic [`TIMER_CHAN_CNT-1:0] tm_tick; // per-channel clock
  logic [`CNT_WIDTH-1:0] tm_count [`TIMER_CHAN_CNT]; // live counts

  // control word captures and byte order per channel
  always_comb
  begin
    nxt_tm_ctrl = tm_ctrl_ff;
    nxt_high_ptr = high_ptr_ff;
    if (tm_wr && addr == `TIMER_CTRL_ADDR)
    begin
      nxt_tm_ctrl = host_data_in;
      // control word for a channel restarts its byte order
      if (host_data_in[7:6] != 2'h3)
      begin
        nxt_high_ptr[host_data_in[7:6]] = 1'b0;
      end
    end
    else if (tm_wr)
    begin
      nxt_high_ptr[addr] = ~high_ptr_ff[addr];
    end
  end

  // timer control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tm_ctrl_ff <= `CTRL_RESET;
      high_ptr_ff <= '0;
    end
    else
    begin
      tm_ctrl_ff <= nxt_tm_ctrl;
      high_ptr_ff <= nxt_high_ptr;
    end
  end

  // timer channels; counting ignores the select
  genvar gi;
  generate
    for (gi = 0; gi < `TIMER_CHAN_CNT; gi = gi + 1)
    begin : g_chan
      assign tm_load[gi] = tm_wr & chan_hit(addr, gi);
      // channel a on the fast clock, the rest on the slow one
      assign tm_tick[gi] = (gi == 0) ? half_tick : sixteenth_tick;
      timer_counter u_cnt
      (
        .clk(clk),
        .rst(rst),
        .tick(tm_tick[gi]),
        .load(tm_load[gi]),
        .load_data(host_data_in),
        .load_high(high_ptr_ff[gi]),
        .count(tm_count[gi]),
        .out(tm_out[gi])
      );
    end
  endgenerate

  // serial controller mode/command state
  sc_state_type sc_state_ff;
  sc_state_type nxt_sc_state;
  logic [7:0] sc_mode_ff; // mode word
  logic [7:0] nxt_sc_mode;
  logic [7:0] sc_cmd_ff; // command word
  logic [7:0] nxt_sc_cmd;
  logic [7:0] sc_tx_ff; // transmit holding byte
  logic [7:0] nxt_sc_tx;
  logic sc_tx_full_ff; // holding byte not yet taken
  logic nxt_sc_tx_full;
  logic [7:0] sc_status; // status as read by the host

  // controller sequencing: mode word, then command, then running
  always_comb
  begin
    nxt_sc_state = sc_state_ff;
    nxt_sc_mode = sc_mode_ff;
    nxt_sc_cmd = sc_cmd_ff;
    nxt_sc_tx = sc_tx_ff;
    nxt_sc_tx_full = sc_tx_full_ff;
    // holding byte drains while the third counter output is high and command bit 0 is set
    if (sc_tx_full_ff && tm_out[2] && sc_cmd_ff[0])
    begin
      nxt_sc_tx_full = 1'b0;
    end
    case (sc_state_ff)
      SC_IDLE:
      begin
        // only a control write leaves idle
        if (sc_wr && addr_bit0 == `SC_CTRL_ADDR)
        begin
          nxt_sc_mode = host_data_in;
          nxt_sc_state = SC_WAIT_CMD;
        end
      end
      SC_WAIT_CMD:
      begin
        if (sc_wr && addr_bit0 == `SC_CTRL_ADDR)
        begin
          nxt_sc_cmd = host_data_in;
          nxt_sc_state = SC_RUN;
        end
      end
      SC_RUN:
      begin
        if (sc_wr && addr_bit0 == `SC_CTRL_ADDR)
        begin
          nxt_sc_cmd = host_data_in;
          // internal reset bit returns to idle
          if (host_data_in[6])
          begin
            nxt_sc_state = SC_IDLE;
          end
        end
        else if (sc_wr)
        begin
          nxt_sc_tx = host_data_in;
          nxt_sc_tx_full = 1'b1;
        end
      end
      default:
      begin
        nxt_sc_state = SC_IDLE;
      end
    endcase
  end

  // controller registers; reset forces idle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sc_state_ff <= SC_IDLE;
      sc_mode_ff <= `CTRL_RESET;
      sc_cmd_ff <= `CTRL_RESET;
      sc_tx_ff <= `CTRL_RESET;
      sc_tx_full_ff <= 1'b0;
    end
    else
    begin
      sc_state_ff <= nxt_sc_state;
      sc_mode_ff <= nxt_sc_mode;
      sc_cmd_ff <= nxt_sc_cmd;
      sc_tx_ff <= nxt_sc_tx;
      sc_tx_full_ff <= nxt_sc_tx_full;
    end
  end

  assign sc_status = {7'h00, ~sc_tx_full_ff};
  // output next values
  logic [7:0] nxt_data_out;
  logic nxt_data_oe;
  logic nxt_irq_a;
  logic nxt_irq_b;
  logic nxt_tx_ready;
  logic [7:0] data_out_ff;
  logic data_oe_ff;
  logic irq_a_ff;
  logic irq_b_ff;
  logic tx_ready_ff;
  logic timer_c_ff;
  logic present_n_ff;
  // read mux, bus enable and interrupt routing
  always_comb
  begin
    nxt_data_out = 8'h00;
    nxt_data_oe = 1'b0;
    nxt_tx_ready = (sc_state_ff == SC_RUN) & sc_cmd_ff[0] & ~sc_tx_full_ff;
    if (!host_read_strobe_n && !serial_ctrl_select_n)
    begin
      nxt_data_oe = 1'b1;
      nxt_data_out = addr_bit0 ? sc_status : sc_tx_ff;
    end
    else if (!host_read_strobe_n && !timer_select_n)
    begin
      nxt_data_oe = 1'b1;
      if (addr == `TIMER_CTRL_ADDR)
      begin
        nxt_data_out = 8'h00; // control word not readable
      end
      else
      begin
        nxt_data_out = high_ptr_ff[addr] ? tm_count[addr][15:8]
                                         : tm_count[addr][7:0];
      end
    end
    nxt_irq_a = irq_pick(irq_a_jumper, tm_out[0], tm_out[1], tx_ready_ff);
    nxt_irq_b = irq_pick(irq_b_jumper, tm_out[0], tm_out[1], tx_ready_ff);
  end

  // output registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_out_ff <= 8'h00;
      data_oe_ff <= 1'b0;
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
      timer_c_ff <= 1'b0;
      present_n_ff <= 1'b0;
    end
    else
    begin
      data_out_ff <= nxt_data_out;
      data_oe_ff <= nxt_data_oe;
      irq_a_ff <= nxt_irq_a;
      irq_b_ff <= nxt_irq_b;
      tx_ready_ff <= nxt_tx_ready;
      timer_c_ff <= tm_out[2];
      present_n_ff <= 1'b0;
    end
  end

  assign host_data_out = data_out_ff;
  assign host_data_oe = data_oe_ff;
  assign irq_out_a = irq_a_ff;
  assign irq_out_b = irq_b_ff;
  assign tx_ready_flag = tx_ready_ff;
  assign timer_out_c = timer_c_ff;
  assign module_present_n = present_n_ff;
endmodule

/* tb/serial_module_host_port_checker.sv */
// pin-level assertions for the serial module host port
`timescale 1ns/1ps
module serial_module_host_port_checker
  import serial_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic addr_bit0,
  input wire logic addr_bit1,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic serial_ctrl_select_n,
  input wire logic timer_select_n,
  input wire logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe,
  input wire logic [1:0] irq_a_jumper,
  input wire logic [1:0] irq_b_jumper,
  input wire logic irq_out_a,
  input wire logic irq_out_b,
  input wire logic timer_out_c,
  input wire logic tx_ready_flag,
  input wire logic module_present_n
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // ready source held steady for three cycles
  sequence ready_steady;
    (irq_a_jumper == IRQ_SRC_TX_READY && tx_ready_flag)[*3];
  endsequence
  a_read_drives_bus: assert property (
    !host_read_strobe_n && !serial_ctrl_select_n |=> host_data_oe) else $error("no read drive");
  a_bus_floats_idle: assert property (
    host_read_strobe_n || (serial_ctrl_select_n && timer_select_n) |=> !host_data_oe)
    else $error("bus driven while idle");
  a_zero_when_off: assert property (
    !host_data_oe |-> host_data_out == 8'h00) else $error("data not zero when off");
  a_oe_has_cause: assert property (
    $rose(host_data_oe) |-> !$past(host_read_strobe_n)) else $error("drive without read");
  a_present_held: assert property (
    module_present_n == 1'b0) else $error("present released");
  a_reset_clears: assert property (
    $fell(rst) |-> !host_data_oe && !tx_ready_flag) else $error("reset not clean");
  a_irq_b_off: assert property (
    irq_b_jumper == IRQ_SRC_OFF |-> ##1 !irq_out_b) else $error("irq b while off");
  a_irq_a_ready: assert property (
    ready_steady |-> irq_out_a) else $error("irq a not following ready");
endmodule
bind serial_module_host_port serial_module_host_port_checker chk (.clk(clk), .rst(rst),
  .addr_bit0(addr_bit0), .addr_bit1(addr_bit1), .host_read_strobe_n(host_read_strobe_n),
  .host_write_strobe_n(host_write_strobe_n), .serial_ctrl_select_n(serial_ctrl_select_n),
  .timer_select_n(timer_select_n), .host_data_in(host_data_in),
  .host_data_out(host_data_out), .host_data_oe(host_data_oe), .irq_a_jumper(irq_a_jumper),
  .irq_b_jumper(irq_b_jumper), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b),
  .timer_out_c(timer_out_c), .tx_ready_flag(tx_ready_flag),
  .module_present_n(module_present_n));

/* tb/host_bus_model.sv */
// host processor model driving the expansion bus cycles
`timescale 1ns/1ps
module host_bus_model
(
  input wire logic clk,
  output logic addr_bit0,
  output logic addr_bit1,
  output logic host_read_strobe_n,
  output logic host_write_strobe_n,
  output logic serial_ctrl_select_n,
  output logic timer_select_n,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe
);
  // bus idle at time zero
  initial
  begin
    {addr_bit0, addr_bit1, host_read_strobe_n, host_write_strobe_n} = 4'hf;
    {serial_ctrl_select_n, timer_select_n} = 2'h3;
    host_data_in = 8'h00;
  end
  // sel: 0 controller, 1 timer, 2 none
  task automatic wr(input logic [1:0] sel, input logic [1:0] a, input logic [7:0] d);
    @(negedge clk);
    serial_ctrl_select_n = (sel != 2'h0);
    timer_select_n = (sel != 2'h1);
    {addr_bit1, addr_bit0} = a;
    host_data_in = d;
    host_write_strobe_n = 1'b0;
    @(negedge clk);
    host_write_strobe_n = 1'b1;
    @(negedge clk);
    {serial_ctrl_select_n, timer_select_n} = 2'h3;
    host_data_in = ~d; // released bus shows no stale value
  endtask
  // read cycle, data taken at the falling edge after the answer is registered
  task automatic rd(input logic [1:0] sel, input logic [1:0] a, output logic [7:0] d,
    output logic o);
    @(negedge clk);
    serial_ctrl_select_n = (sel != 2'h0);
    timer_select_n = (sel != 2'h1);
    {addr_bit1, addr_bit0} = a;
    host_read_strobe_n = 1'b0;
    @(posedge clk);
    @(negedge clk);
    d = host_data_out; // settled one edge after the request
    o = host_data_oe;
    @(negedge clk);
    host_read_strobe_n = 1'b1;
    {serial_ctrl_select_n, timer_select_n} = 2'h3;
  endtask
endmodule

/* tb/tb_serial_module_host_port.sv */
// self-checking bench for the serial module host port
`timescale 1ns/1ps
module tb_serial_module_host_port;
  import serial_port_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic a0, a1, rd_n, wr_n, cs0_n, cs1_n, oe, irq_a, irq_b, out_c, txr, pres_n;
  logic [7:0] din, dout;
  logic [1:0] ja = 2'h2;
  logic [1:0] jb = 2'h0;
  int fail_count = 0;
  int n_compared = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  serial_module_host_port dut (.clk(clk), .rst(rst), .addr_bit0(a0), .addr_bit1(a1),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .serial_ctrl_select_n(cs0_n),
    .timer_select_n(cs1_n), .host_data_in(din), .host_data_out(dout), .host_data_oe(oe),
    .irq_a_jumper(ja), .irq_b_jumper(jb), .irq_out_a(irq_a), .irq_out_b(irq_b),
    .timer_out_c(out_c), .tx_ready_flag(txr), .module_present_n(pres_n));
  host_bus_model host (.clk(clk), .addr_bit0(a0), .addr_bit1(a1), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .serial_ctrl_select_n(cs0_n), .timer_select_n(cs1_n),
    .host_data_in(din), .host_data_out(dout), .host_data_oe(oe));
  // comparisons
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic chk_int(input int got, input int exp);
    n_compared++;
    if (got != exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_sim;
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic sig(input bit w);
    return w ? irq_b : out_c;
  endfunction
  // cycles between the 2nd and 3rd level change of a timer output
  task automatic gap(input bit w, output int n);
    int e;
    logic v;
    e = 0;
    n = 0;
    v = sig(w);
    repeat (3000)
    begin
      @(negedge clk);
      if (sig(w) !== v)
      begin
        v = sig(w);
        e++;
        if (e == 3)
          break;
        n = 0;
      end
      else
        n++;
    end
  endtask
  task t_reset;
    chk_bit(oe, 1'b0);
    chk_bit(txr, 1'b0);
    chk_bit(pres_n, 1'b0);
  endtask
  task t_timer;
    int n;
    logic [7:0] d;
    logic o;
    host.wr(2'h1, 2'h3, 8'h80);
    host.wr(2'h1, 2'h2, 8'h04);
    host.wr(2'h1, 2'h2, 8'h00);
    gap(1'b0, n);
    chk_int(n + 1, 64);
    host.wr(2'h1, 2'h3, 8'h00);
    host.wr(2'h1, 2'h0, 8'h04);
    host.wr(2'h1, 2'h0, 8'h00);
    gap(1'b1, n);
    chk_int(n + 1, 8);
    host.wr(2'h1, 2'h3, 8'h40);
    host.wr(2'h1, 2'h1, 8'h04);
    host.wr(2'h1, 2'h1, 8'h00);
    jb = 2'h1;
    gap(1'b1, n);
    chk_int(n + 1, 64);
    host.rd(2'h1, 2'h3, d, o);
    chk_byte(d, 8'h00);
    host.rd(2'h1, 2'h1, d, o);
    chk_bit(o, 1'b1);
    jb = 2'h3;
    repeat (3) @(negedge clk);
    chk_bit(irq_b, 1'b0);
  endtask
  task t_ctrl;
    logic [7:0] d;
    logic o;
    host.wr(2'h0, 2'h1, 8'h4e);
    host.wr(2'h0, 2'h1, 8'h01);
    host.rd(2'h0, 2'h1, d, o);
    chk_bit(o, 1'b1);
    chk_bit(d[0], 1'b1);
    chk_bit(txr, 1'b1);
    chk_bit(irq_a, 1'b1);
    host.wr(2'h0, 2'h0, 8'h5a);
    host.wr(2'h2, 2'h0, 8'ha5);
    host.rd(2'h2, 2'h0, d, o);
    chk_bit(o, 1'b0);
    host.rd(2'h0, 2'h0, d, o);
    chk_byte(d, 8'h5a);
  endtask
  task t_idle;
    host.wr(2'h0, 2'h1, 8'h40);
    repeat (2) @(negedge clk);
    chk_bit(txr, 1'b0);
    host.wr(2'h0, 2'h1, 8'h01);
    repeat (2) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk_bit(txr, 1'b0);
    chk_bit(oe, 1'b0);
    // after reset the first control word is a mode word again
    host.wr(2'h0, 2'h1, 8'h01);
    repeat (2) @(negedge clk);
    chk_bit(txr, 1'b0);
    host.wr(2'h0, 2'h1, 8'h01);
    repeat (2) @(negedge clk);
    chk_bit(txr, 1'b1);
  endtask
  // main sequence
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset;
    t_timer;
    t_ctrl;
    t_idle;
    end_sim;
  end
  // watchdog
  initial
  begin
    #(25 * 20000);
    fail_count++;
    end_sim;
  end
endmodule
